// ---- flash_prot_defines.svh ----
/*
  constants of the serial flash protection and setup block: bit
  positions, reset values, widths and the sector geometry.
  assumes it is included once per compile unit by bare name.
*/
// Behaviour
// - lock bit set refuses block-protect, parameter-place and origin writes till power-on.
// - with lock bit clear, lock and four-lane bits are writable; bits 2, 3 and 5 can only be raised.
// - setup bit 1 selects four lanes; protect and pause pins become data lanes.
// - setup bit 2 puts thirty-two 4 KB sectors at top, else at bottom.
// - setup bit 3 makes block-protect volatile, loaded with 111 at power-on.
// - setup bit 5 zero protects downward from top, one upward from zero.
// - bits 7, 6 and 4 unused or reserved; all bits start at 0.
// - modifying commands need the write enable latch set by write-unlock.
// - latch clears at power-up and after program, erase, register write, write-lock.
// - protected addresses stay readable; program and erase to them are refused.
// - origin top: code n protects top 2^(n-1) 64 KB sectors; 0 none, 7 all.
// - origin bottom: code n protects lowest 2^(n-1) sectors; 0 none, 7 all.
// - pin guard comes from the protect pin level and the status-lock bit.
// - outside four-lane mode, status-lock set with protect pin low freezes status-lock and block-protect.
// - program, erase and register write need a clock count multiple of eight.
// - pause stops only the serial link; running operations carry on.
// - pause starts at pause pin fall if clock low, else at next clock fall.
// - pause ends at pin rise if clock low, else next clock fall; output floats.
// - select rising during pause resets the interface logic.
// - pause is off in four-lane mode; single and dual reads unaffected.
`ifndef FLASH_PROT_DEFINES_SVH
`define FLASH_PROT_DEFINES_SVH

// setup register field positions
`define CFG_LOCK_BIT 0
`define CFG_FOUR_LANE_BIT 1
`define CFG_PARAM_TOP_BIT 2
`define CFG_BP_VOLATILE_BIT 3
`define CFG_FROM_BOTTOM_BIT 5
`define CFG_RESET 8'h00
// setup bits that may only be raised
`define CFG_ONE_TIME_MASK 8'h2c
// setup bits that are writable at all
`define CFG_WRITABLE_MASK 8'h2f

// status view field positions
`define ST_BUSY_BIT 0
`define ST_WEL_BIT 1
`define ST_BP_LSB 2
`define ST_LOCK_BIT 7
`define BP_ALL 3'h7
`define BP_NONE 3'h0

// array geometry
`define ADDR_W 22
`define SECTOR_LSB 16
`define SECTOR_W 6
`define SECTOR_COUNT 7'h40
`define PARAM_LSB 17

// serial framing
`define BITS_PER_BYTE 8
`define BIT_CNT_W 3
`define SYNC_STAGES 3
`define SYNC_W 5

`endif

// ---- flash_prot_pkg.sv ----
/*
  types shared by the protection and setup block and its users.
  assumes flash_prot_defines.svh is on the include path.
*/
`include "flash_prot_defines.svh"
package flash_prot_pkg;

  typedef enum logic [3:0] {
    CMD_NONE = 4'h0,
    CMD_WRITE_UNLOCK = 4'h1,
    CMD_WRITE_LOCK = 4'h2,
    CMD_REGISTER_WRITE = 4'h3,
    CMD_PAGE_WRITE = 4'h4,
    CMD_FOUR_LANE_PAGE_WRITE = 4'h5,
    CMD_BLOCK64K_WIPE = 4'h6,
    CMD_SMALL4K_WIPE = 4'h7,
    CMD_SMALL8K_WIPE = 4'h8,
    CMD_FULL_CHIP_WIPE = 4'h9,
    CMD_ONE_TIME_AREA_WRITE = 4'ha,
    CMD_READ = 4'hb
  } cmd_kind_t;

  typedef struct packed {
    logic [1:0] unused;
    logic protect_from_bottom;
    logic reserved;
    logic protect_bits_volatile;
    logic param_sector_top_select;
    logic four_lane;
    logic cfg_lock;
  } cfg_t;

  typedef struct packed {
    cmd_kind_t kind;
    logic [`ADDR_W-1:0] addr;
    logic [7:0] status_byte;
    logic [7:0] cfg_byte;
    logic has_cfg;
  } cmd_t;

  typedef enum logic [1:0] {
    LINK_IDLE = 2'b00,
    LINK_FRAME = 2'b01,
    LINK_PAUSED = 2'b10
  } link_state_t;

endpackage

// ---- serial_flash_protect_config.sv ----
/*
  protection and setup logic of a serial flash: setup register, block
  protect decode, write enable latch, pin guard, clock count check and
  the serial pause function.
  assumes a command decoder on sys_clk presents each command with
  cmd_valid before the select pin rises, and a retained store that
  holds nv_cfg and nv_block_protect steady across reset.
*/
`timescale 1ns/1ps
`default_nettype none
`include "flash_prot_defines.svh"
module serial_flash_protect_config (
  // clocks, reset, enable
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  // serial link pins
  input wire logic sck,
  input wire logic cs_n,
  input wire logic pause_n_pin,
  input wire logic write_protect_n_pin,
  // command from the decoder
  input wire logic cmd_valid,
  input wire flash_prot_pkg::cmd_t cmd,
  input wire logic op_done,
  input wire logic op_busy,
  // retained storage image
  input wire flash_prot_pkg::cfg_t nv_cfg,
  input wire logic [2:0] nv_block_protect,
  input wire logic nv_status_lock,
  // register state
  output flash_prot_pkg::cfg_t cfg_q,
  output logic [2:0] block_protect_field,
  output logic status_lock_bit,
  output logic write_enable_latch,
  output logic [7:0] status_view,
  output logic pin_guard_mode,
  output logic setup_ready,
  // command outcome
  output logic exec_pulse,
  output flash_prot_pkg::cmd_kind_t exec_kind,
  output logic refuse_pulse,
  output logic param_hit,
  output logic nv_store_pulse,
  // link side
  output logic link_paused,
  output logic so_float
);
  import flash_prot_pkg::*;

  // ==========================================================
  // helpers
  function automatic logic addr_protected(
    input logic [`ADDR_W-1:0] a,
    input logic [2:0] bp,
    input logic from_bottom
  );
    logic [6:0] span;
    logic [6:0] sec;
    span = 7'h01 << (bp - 3'h1);
    sec = {1'b0, a[`ADDR_W-1:`SECTOR_LSB]};
    if (bp == `BP_NONE) begin
      addr_protected = 1'b0;
    end else if (bp == `BP_ALL) begin
      addr_protected = 1'b1;
    end else if (from_bottom) begin
      addr_protected = sec < span;
    end else begin
      addr_protected = sec >= (`SECTOR_COUNT - span);
    end
  endfunction

  function automatic logic needs_latch(input cmd_kind_t k);
    needs_latch = !(k inside {CMD_NONE, CMD_WRITE_UNLOCK, CMD_WRITE_LOCK,
                              CMD_READ});
  endfunction

  function automatic logic is_addressed(input cmd_kind_t k);
    is_addressed = k inside {CMD_PAGE_WRITE, CMD_FOUR_LANE_PAGE_WRITE,
                             CMD_BLOCK64K_WIPE, CMD_SMALL4K_WIPE,
                             CMD_SMALL8K_WIPE};
  endfunction

  // ==========================================================
  // link clock domain: clock pulse counter
  // the frame flag is cleared by the select pin itself, since sck may
  // stand still once the frame is over
  cfg_t cfg_ff;
  cfg_t nxt_cfg;
  logic in_frame_ff;
  logic [`BIT_CNT_W-1:0] bit_cnt_ff;
  logic [`BIT_CNT_W-1:0] nxt_bit_cnt;
  logic four_lane_l1_ff;
  logic four_lane_l2_ff;
  logic aligned_ff;
  logic nxt_aligned;

  always_comb begin
    nxt_bit_cnt = bit_cnt_ff;
    // pause drops clock pulses; in four-lane mode the pin is data
    if (pause_n_pin || four_lane_l2_ff) begin
      nxt_bit_cnt = in_frame_ff ? bit_cnt_ff + 3'h1 : 3'h1;
    end
    nxt_aligned = (nxt_bit_cnt == '0);
  end

  always_ff @(posedge sck or posedge rst or posedge cs_n) begin
    if (rst || cs_n) begin
      in_frame_ff <= 1'b0;
    end else begin
      in_frame_ff <= 1'b1;
    end
  end

  always_ff @(posedge sck or posedge rst) begin
    if (rst) begin
      bit_cnt_ff <= '0;
      aligned_ff <= 1'b1;
      four_lane_l1_ff <= 1'b0;
      four_lane_l2_ff <= 1'b0;
    end else begin
      bit_cnt_ff <= nxt_bit_cnt;
      aligned_ff <= nxt_aligned;
      four_lane_l1_ff <= cfg_ff.four_lane;
      four_lane_l2_ff <= four_lane_l1_ff;
    end
  end

  // ==========================================================
  // input synchronisers
  // a change counts once the second and third stages agree
  logic [`SYNC_W-1:0] sync_in;
  logic [`SYNC_W-1:0] sync1_ff;
  logic [`SYNC_W-1:0] sync2_ff;
  logic [`SYNC_W-1:0] sync3_ff;
  logic [`SYNC_W-1:0] stable_ff;
  logic [`SYNC_W-1:0] nxt_stable;

  assign sync_in = {aligned_ff, write_protect_n_pin, pause_n_pin, cs_n, sck};

  genvar gi;
  generate
    for (gi = 0; gi < `SYNC_W; gi++) begin : g_sync
      always_comb begin
        nxt_stable[gi] = stable_ff[gi];
        if (sync2_ff[gi] == sync3_ff[gi]) begin
          nxt_stable[gi] = sync3_ff[gi];
        end
      end
    end
  endgenerate

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sync1_ff <= 5'h1e;
      sync2_ff <= 5'h1e;
      sync3_ff <= 5'h1e;
      stable_ff <= 5'h1e;
    end else if (ce) begin
      sync1_ff <= sync_in;
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
      stable_ff <= nxt_stable;
    end
  end

  logic sck_s;
  logic cs_n_s;
  logic pause_n_s;
  logic wp_n_s;
  logic aligned_s;
  assign sck_s = stable_ff[0];
  assign cs_n_s = stable_ff[1];
  assign pause_n_s = stable_ff[2];
  assign wp_n_s = stable_ff[3];
  assign aligned_s = stable_ff[4];

  // ==========================================================
  // link state and pause
  link_state_t link_ff;
  link_state_t nxt_link;
  logic cs_prev_ff;
  logic frame_end;
  logic frame_abort;

  always_comb begin
    nxt_link = link_ff;
    case (link_ff)
      LINK_IDLE: begin
        if (!cs_n_s) begin
          nxt_link = LINK_FRAME;
        end
      end
      LINK_FRAME: begin
        if (cs_n_s) begin
          nxt_link = LINK_IDLE;
        end else if (!cfg_ff.four_lane && !pause_n_s && !sck_s) begin
          // a fall while sck is high waits here for sck to go low
          nxt_link = LINK_PAUSED;
        end
      end
      LINK_PAUSED: begin
        if (cs_n_s) begin
          nxt_link = LINK_IDLE;
        end else if (cfg_ff.four_lane || (pause_n_s && !sck_s)) begin
          nxt_link = LINK_FRAME;
        end
      end
      default: begin
        nxt_link = LINK_IDLE;
      end
    endcase
  end

  assign frame_end = !cs_prev_ff && cs_n_s && link_ff == LINK_FRAME;
  assign frame_abort = !cs_prev_ff && cs_n_s && link_ff == LINK_PAUSED;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      link_ff <= LINK_IDLE;
      cs_prev_ff <= 1'b1;
    end else if (ce) begin
      link_ff <= nxt_link;
      cs_prev_ff <= cs_n_s;
    end
  end

  // ==========================================================
  // setup, status and latch
  logic [2:0] bp_ff;
  logic [2:0] nxt_bp;
  logic lock_ff;
  logic nxt_lock;
  logic wel_ff;
  logic nxt_wel;
  logic loaded_ff;
  logic nxt_loaded;
  cmd_t pend_ff;
  cmd_t nxt_pend;
  logic pend_valid_ff;
  logic nxt_pend_valid;
  logic exec_ff;
  logic nxt_exec;
  logic refuse_ff;
  logic nxt_refuse;
  cmd_kind_t exec_kind_ff;
  cmd_kind_t nxt_exec_kind;
  logic param_hit_ff;
  logic nxt_param_hit;
  logic store_ff;
  logic nxt_store;
  logic guard;
  logic go;
  logic [7:0] cfg_wr;
  logic [2:0] bp_wr;

  // protect pin is a data lane in four-lane mode, so it cannot guard
  assign guard = lock_ff && !wp_n_s && !cfg_ff.four_lane;

  always_comb begin
    nxt_cfg = cfg_ff;
    nxt_bp = bp_ff;
    nxt_lock = lock_ff;
    nxt_wel = wel_ff;
    nxt_loaded = 1'b1;
    nxt_pend = pend_ff;
    nxt_pend_valid = pend_valid_ff;
    nxt_exec = 1'b0;
    nxt_refuse = 1'b0;
    nxt_exec_kind = exec_kind_ff;
    nxt_param_hit = param_hit_ff;
    nxt_store = 1'b0;
    go = 1'b0;
    cfg_wr = cfg_ff;
    bp_wr = bp_ff;
    if (!loaded_ff) begin
      // retained image, lock bit forced clear
      nxt_cfg = nv_cfg & cfg_t'(`CFG_WRITABLE_MASK);
      nxt_cfg.cfg_lock = 1'b0;
      nxt_lock = nv_status_lock;
      nxt_bp = nv_cfg.protect_bits_volatile ? `BP_ALL
                                            : nv_block_protect;
    end else begin
      if (cmd_valid) begin
        nxt_pend = cmd;
        nxt_pend_valid = 1'b1;
      end
      if (frame_abort) begin
        // a command taken in this very cycle belongs to the next frame
        nxt_pend_valid = cmd_valid;
      end else if (frame_end && pend_valid_ff) begin
        nxt_pend_valid = cmd_valid;
        nxt_exec_kind = pend_ff.kind;
        nxt_param_hit = cfg_ff.param_sector_top_select
          ? &pend_ff.addr[`ADDR_W-1:`PARAM_LSB]
          : ~|pend_ff.addr[`ADDR_W-1:`PARAM_LSB];
        go = 1'b1;
        if (needs_latch(pend_ff.kind) && !wel_ff) begin
          go = 1'b0;
        end
        if (pend_ff.kind != CMD_READ && !aligned_s) begin
          go = 1'b0;
        end
        if (is_addressed(pend_ff.kind)
            && addr_protected(pend_ff.addr, bp_ff,
                              cfg_ff.protect_from_bottom)) begin
          go = 1'b0;
        end
        if (pend_ff.kind == CMD_FULL_CHIP_WIPE && bp_ff != `BP_NONE) begin
          go = 1'b0;
        end
        nxt_exec = go;
        nxt_refuse = !go;
        if (go) begin
          case (pend_ff.kind)
            CMD_WRITE_UNLOCK: begin
              nxt_wel = 1'b1;
            end
            CMD_WRITE_LOCK: begin
              nxt_wel = 1'b0;
            end
            CMD_REGISTER_WRITE: begin
              nxt_wel = 1'b0;
              bp_wr = pend_ff.status_byte[`ST_BP_LSB +: 3];
              if (!guard) begin
                nxt_lock = pend_ff.status_byte[`ST_LOCK_BIT];
                if (!cfg_ff.cfg_lock) begin
                  nxt_bp = bp_wr;
                end
              end else begin
                nxt_lock = lock_ff;
              end
              if (pend_ff.has_cfg) begin
                cfg_wr = pend_ff.cfg_byte & `CFG_WRITABLE_MASK;
                // one-time bits merge upward only
                cfg_wr = cfg_wr | (cfg_ff & `CFG_ONE_TIME_MASK);
                if (cfg_ff.cfg_lock) begin
                  // lock holds until power-on
                  cfg_wr[`CFG_LOCK_BIT] = 1'b1;
                  cfg_wr[`CFG_PARAM_TOP_BIT] =
                    cfg_ff.param_sector_top_select;
                  cfg_wr[`CFG_FROM_BOTTOM_BIT] =
                    cfg_ff.protect_from_bottom;
                end
                nxt_cfg = cfg_t'(cfg_wr);
              end
              nxt_store = 1'b1;
            end
            default: begin
              nxt_wel = wel_ff;
            end
          endcase
        end
      end
      // program and erase finish later; latch drops on completion
      if (op_done && !(go && pend_ff.kind == CMD_WRITE_UNLOCK)) begin
        nxt_wel = 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cfg_ff <= cfg_t'(`CFG_RESET);
      bp_ff <= `BP_NONE;
      lock_ff <= 1'b0;
      wel_ff <= 1'b0;
      loaded_ff <= 1'b0;
      pend_ff <= '0;
      pend_valid_ff <= 1'b0;
      exec_ff <= 1'b0;
      refuse_ff <= 1'b0;
      exec_kind_ff <= CMD_NONE;
      param_hit_ff <= 1'b0;
      store_ff <= 1'b0;
    end else if (ce) begin
      cfg_ff <= nxt_cfg;
      bp_ff <= nxt_bp;
      lock_ff <= nxt_lock;
      wel_ff <= nxt_wel;
      loaded_ff <= nxt_loaded;
      pend_ff <= nxt_pend;
      pend_valid_ff <= nxt_pend_valid;
      exec_ff <= nxt_exec;
      refuse_ff <= nxt_refuse;
      exec_kind_ff <= nxt_exec_kind;
      param_hit_ff <= nxt_param_hit;
      store_ff <= nxt_store;
    end
  end

  // ==========================================================
  // registered outputs
  logic [7:0] nxt_view;
  logic [7:0] view_ff;
  logic guard_ff;
  logic paused_ff;
  logic ready_ff;

  always_comb begin
    nxt_view = 8'h00;
    nxt_view[`ST_BUSY_BIT] = op_busy;
    nxt_view[`ST_WEL_BIT] = wel_ff;
    nxt_view[`ST_BP_LSB +: 3] = bp_ff;
    nxt_view[`ST_LOCK_BIT] = lock_ff;
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      view_ff <= 8'h00;
      guard_ff <= 1'b0;
      paused_ff <= 1'b0;
      ready_ff <= 1'b0;
    end else if (ce) begin
      view_ff <= nxt_view;
      guard_ff <= guard;
      paused_ff <= (nxt_link == LINK_PAUSED);
      ready_ff <= loaded_ff;
    end
  end

  assign cfg_q = cfg_ff;
  assign block_protect_field = bp_ff;
  assign status_lock_bit = lock_ff;
  assign write_enable_latch = wel_ff;
  assign status_view = view_ff;
  assign pin_guard_mode = guard_ff;
  assign setup_ready = ready_ff;
  assign exec_pulse = exec_ff;
  assign exec_kind = exec_kind_ff;
  assign refuse_pulse = refuse_ff;
  assign param_hit = param_hit_ff;
  assign nv_store_pulse = store_ff;
  assign link_paused = paused_ff;
  assign so_float = paused_ff;

endmodule
`default_nettype wire

// ---- serial_flash_protect_config_assertions.sv ----
/*
  concurrent checks of the protection and setup block at its ports.
  assumes ce stays high and a bind from the bench top file.
*/
`timescale 1ns/1ps
`default_nettype none
module serial_flash_protect_config_assertions (
  // clock, reset and operation done
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic op_done,
  // watched outputs
  input wire flash_prot_pkg::cfg_t cfg_q,
  input wire logic [2:0] block_protect_field,
  input wire logic status_lock_bit,
  input wire logic write_enable_latch,
  input wire logic pin_guard_mode,
  input wire logic setup_ready,
  input wire logic exec_pulse,
  input wire flash_prot_pkg::cmd_kind_t exec_kind,
  input wire logic refuse_pulse,
  input wire logic link_paused,
  input wire logic so_float
);
  import flash_prot_pkg::*;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // ==========================================
  // setup register
  a_lock_freezes: assert property (cfg_q.cfg_lock |=> cfg_q.cfg_lock &&
    $stable(block_protect_field) && $stable(cfg_q.protect_from_bottom) &&
    $stable(cfg_q.param_sector_top_select)) else $error("lock breached");
  a_one_time_bits: assert property (setup_ready |=>
    !$fell(cfg_q.param_sector_top_select) && !$fell(cfg_q.protect_from_bottom)
    && !$fell(cfg_q.protect_bits_volatile)) else $error("one-time bit fell");
  a_unused_bits: assert property (cfg_q.unused == 2'h0 && !cfg_q.reserved)
    else $error("unused bit set");
  a_boot_volatile: assert property ($rose(setup_ready) &&
    cfg_q.protect_bits_volatile |-> block_protect_field == 3'h7)
    else $error("volatile protect not all");
  a_boot_unlock: assert property ($rose(setup_ready) |->
    !cfg_q.cfg_lock && !write_enable_latch) else $error("boot state wrong");
  // ==========================================
  // write enable latch
  a_latch_by_unlock: assert property ($rose(write_enable_latch) |->
    exec_pulse && exec_kind == CMD_WRITE_UNLOCK) else $error("latch rose");
  a_modify_needs_latch: assert property (exec_pulse && !(exec_kind inside
    {CMD_WRITE_UNLOCK, CMD_WRITE_LOCK, CMD_READ}) |-> $past(write_enable_latch))
    else $error("modify without latch");
  a_latch_clears: assert property (exec_pulse && exec_kind inside
    {CMD_WRITE_LOCK, CMD_REGISTER_WRITE} |-> !write_enable_latch)
    else $error("latch kept");
  a_done_clears: assert property (op_done |=> !write_enable_latch ||
    (exec_pulse && exec_kind == CMD_WRITE_UNLOCK))
    else $error("latch kept after done");
  a_wipe_unguarded: assert property (exec_pulse &&
    exec_kind == CMD_FULL_CHIP_WIPE |-> block_protect_field == 3'h0)
    else $error("full wipe under protection");
  // ==========================================
  // pin guard and pause
  a_guard_source: assert property (pin_guard_mode |-> status_lock_bit)
    else $error("guard without lock");
  a_guard_freezes: assert property (pin_guard_mode |->
    $stable(block_protect_field) && status_lock_bit) else $error("guard leak");
  a_float_pause: assert property (so_float == link_paused)
    else $error("float not with pause");
  a_quad_no_pause: assert property (cfg_q.four_lane |-> ##[0:8] !link_paused)
    else $error("pause in four-lane");
  c_unlock: cover property (exec_pulse && exec_kind == CMD_WRITE_UNLOCK);
  c_refuse: cover property (refuse_pulse);
  c_paused: cover property (link_paused);
  c_guard: cover property (pin_guard_mode);
endmodule
`default_nettype wire

// ---- spi_host_model.sv ----
/*
  host side of the serial link: select, mode 0 clock and pause pin.
  assumes the bench calls frame once per command.
*/
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
  // link pins
  output logic cs_n,
  output logic sck,
  output logic pause_n_pin
);
  initial begin
    cs_n = 1'b1;
    sck = 1'b0;
    pause_n_pin = 1'b1;
  end
  // ==========================================
  // frames; clock stands low outside them
  task automatic tick();
    #80 sck = 1'b1;
    #80 sck = 1'b0;
  endtask
  // pz 1 pauses mid-frame, 2 drops select while paused
  task automatic frame(input int n, input int pz);
    #7 cs_n = 1'b0;
    for (int i = 0; i < n; i++) begin
      tick();
      if (pz != 0 && i == 3) begin
        #40 pause_n_pin = 1'b0;
        repeat (4) tick();
        if (pz == 2) begin
          #40 cs_n = 1'b1;
          #40 pause_n_pin = 1'b1;
          return;
        end
        #40 pause_n_pin = 1'b1;
      end
    end
    #80 cs_n = 1'b1;
  endtask
endmodule
`default_nettype wire

// ---- tb.sv ----
/*
  self-checking bench of the protection and setup block.
  assumes the host model and the bound checker alongside.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
  import flash_prot_pkg::*;
  localparam logic [1:0] E = 2'b10, R = 2'b01, N = 2'b00, X = 2'b11;
  logic sys_clk = 1'b0, rst = 1'b1, ce = 1'b1, cmd_valid = 1'b0;
  logic op_done = 1'b0, op_busy = 1'b0, write_protect_n_pin = 1'b1;
  logic cs_n, sck, pause_n_pin, quad = 1'b0;
  cmd_t cmd = '0;
  cfg_t cfg_q, nv_cfg = 8'h09;
  logic [2:0] block_protect_field, nv_block_protect = 3'h2;
  logic nv_status_lock = 1'b0, status_lock_bit, write_enable_latch;
  logic pin_guard_mode, setup_ready, exec_pulse, refuse_pulse;
  logic param_hit, link_paused, so_float, nv_store_pulse;
  logic [7:0] status_view;
  cmd_kind_t exec_kind;
  int err_count = 0, checks_done = 0, stores = 0;
  serial_flash_protect_config u_dut (.sys_clk, .rst, .ce, .sck, .cs_n,
    .pause_n_pin, .write_protect_n_pin, .cmd_valid, .cmd, .op_done,
    .op_busy, .nv_cfg, .nv_block_protect, .nv_status_lock, .cfg_q,
    .block_protect_field, .status_lock_bit, .write_enable_latch,
    .status_view, .pin_guard_mode, .setup_ready, .exec_pulse, .exec_kind,
    .refuse_pulse, .param_hit, .nv_store_pulse, .link_paused, .so_float);
  spi_host_model host (.cs_n, .sck, .pause_n_pin);
  always #2 sys_clk = ~sys_clk;
  // register writes handed to the retained store
  always @(posedge sys_clk) begin
    if (nv_store_pulse === 1'b1) stores++;
  end
  // ==========================================
  // shared tasks
  task automatic chk(input string nm, input logic [7:0] e, g);
    checks_done++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic op(input cmd_kind_t k, input int sec, input logic [7:0] st,
    cf, input int n, pz, input logic [1:0] e);
    logic [1:0] seen;
    seen = 2'b00;
    @(posedge sys_clk);
    cmd <= '{k, 22'(sec) << 16, st, cf, 1'b1};
    cmd_valid <= 1'b1;
    @(posedge sys_clk);
    cmd_valid <= 1'b0;
    fork
      host.frame(n, pz);
      begin
        #1000;
        if (pz == 1) begin
          chk("paused", 8'(!quad), 8'(link_paused));
          chk("so float", 8'(!quad), 8'(so_float));
        end
      end
    join
    repeat (40) begin
      @(negedge sys_clk);
      seen |= {exec_pulse, refuse_pulse};
    end
    if (e != X) chk("outcome", 8'(e), 8'(seen));
  endtask
  task automatic ul();
    op(CMD_WRITE_UNLOCK, 0, 8'h00, 8'h00, 8, 0, E);
  endtask
  task automatic rw(input logic [7:0] st, cf, input logic [1:0] e);
    ul();
    op(CMD_REGISTER_WRITE, 0, st, cf, 24, 0, e);
  endtask
  task automatic done();
    @(posedge sys_clk);
    op_busy <= 1'b1;
    repeat (4) @(posedge sys_clk);
    op_busy <= 1'b0;
    op_done <= 1'b1;
    @(posedge sys_clk);
    op_done <= 1'b0;
    @(negedge sys_clk);
    chk("latch", 8'h00, 8'(write_enable_latch));
  endtask
  task automatic guard_to(input logic v);
    @(posedge sys_clk);
    write_protect_n_pin <= !v;
    for (int i = 0; i < 20 && pin_guard_mode !== v; i++) @(posedge sys_clk);
    chk("guard", 8'(v), 8'(pin_guard_mode));
  endtask
  // ==========================================
  // scenarios
  task automatic t_reset();
    for (int i = 0; i < 50 && setup_ready !== 1'b1; i++) @(posedge sys_clk);
    if (setup_ready !== 1'b1) begin
      err_count++;
      complete_run();
    end
    @(negedge sys_clk);
    chk("cfg", 8'h08, cfg_q);
    chk("bp", 8'h07, 8'(block_protect_field));
    chk("latch", 8'h00, 8'(write_enable_latch));
    $display("test reset done");
  endtask
  task automatic t_count();
    cmd_kind_t ks[6] = '{CMD_PAGE_WRITE, CMD_FOUR_LANE_PAGE_WRITE,
      CMD_BLOCK64K_WIPE, CMD_SMALL4K_WIPE, CMD_SMALL8K_WIPE,
      CMD_ONE_TIME_AREA_WRITE};
    ul();
    op(CMD_REGISTER_WRITE, 0, 8'h00, 8'h08, 20, 0, R);
    rw(8'h00, 8'h08, E);
    chk("bp", 8'h00, 8'(block_protect_field));
    chk("latch", 8'h00, 8'(write_enable_latch));
    ul();
    op(CMD_FULL_CHIP_WIPE, 0, 8'h00, 8'h00, 8, 0, E);
    done();
    op(CMD_PAGE_WRITE, 5, 8'h00, 8'h00, 32, 0, R);
    ul();
    chk("latch", 8'h01, 8'(write_enable_latch));
    op(CMD_WRITE_LOCK, 0, 8'h00, 8'h00, 8, 0, E);
    chk("latch", 8'h00, 8'(write_enable_latch));
    foreach (ks[j]) begin
      ul();
      op(ks[j], 5, 8'h00, 8'h00, 32, 0, E);
      done();
    end
    $display("test latch and count done");
  endtask
  task automatic t_decode(input logic fb);
    int p;
    for (int c = 1; c < 8; c++) begin
      p = fb ? (1 << (c - 1)) - 1 : 64 - (1 << (c - 1));
      rw({3'h0, 3'(c), 2'h0}, fb ? 8'h2c : 8'h08, E);
      ul();
      op(CMD_PAGE_WRITE, p, 8'h00, 8'h00, 8, 0, R);
      op(CMD_READ, p, 8'h00, 8'h00, 8, 0, E);
      chk("param hit", 8'(fb ? p >= 62 : p <= 1), 8'(param_hit));
      if (c < 7) begin
        ul();
        op(CMD_BLOCK64K_WIPE, fb ? p + 1 : p - 1, 8'h00, 8'h00, 8, 0, E);
        done();
      end
    end
    $display("test decode done");
  endtask
  task automatic t_guard();
    rw(8'h80, 8'h2c, E);
    guard_to(1'b1);
    rw(8'h1c, 8'h2c, X);
    chk("bp", 8'h00, 8'(block_protect_field));
    chk("status lock", 8'h01, 8'(status_lock_bit));
    chk("status view", 8'h80, status_view);
    guard_to(1'b0);
    rw(8'h00, 8'h2c, E);
    chk("status lock", 8'h00, 8'(status_lock_bit));
    $display("test guard done");
  endtask
  task automatic t_pause();
    op(CMD_WRITE_UNLOCK, 0, 8'h00, 8'h00, 8, 1, E);
    op(CMD_WRITE_LOCK, 0, 8'h00, 8'h00, 8, 2, N);
    chk("latch", 8'h01, 8'(write_enable_latch));
    rw(8'h00, 8'h2e, E);
    quad = 1'b1;
    op(CMD_WRITE_UNLOCK, 0, 8'h00, 8'h00, 8, 1, X);
    rw(8'h00, 8'h2c, E);
    quad = 1'b0;
    chk("cfg", 8'h2c, cfg_q);
    $display("test pause done");
  endtask
  task automatic t_lock();
    int n;
    rw(8'h00, 8'h00, X);
    chk("cfg", 8'h2c, cfg_q);
    n = stores;
    rw(8'h00, 8'h2d, E);
    chk("store", 8'h01, 8'(stores - n));
    chk("cfg", 8'h2d, cfg_q);
    rw(8'h0c, 8'h0c, X);
    chk("cfg", 8'h2d, cfg_q);
    chk("bp", 8'h00, 8'(block_protect_field));
    $display("test lock done");
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    t_reset();
    t_count();
    t_decode(1'b0);
    t_decode(1'b1);
    t_guard();
    t_pause();
    t_lock();
    @(posedge sys_clk);
    rst <= 1'b1;
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    t_reset();
    complete_run();
  end
endmodule
bind serial_flash_protect_config serial_flash_protect_config_assertions
  u_chk (.sys_clk, .rst, .op_done, .cfg_q, .block_protect_field,
  .status_lock_bit, .write_enable_latch, .pin_guard_mode, .setup_ready,
  .exec_pulse, .exec_kind, .refuse_pulse, .link_paused, .so_float);
`default_nettype wire
